// >>> bench/fai_net_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: the network port's physical layer as seen by the indicator logic
module fai_net_model (
  input wire logic pclk,
  input wire logic link_up,
  input wire logic traffic_en,
  output logic valid_pin,
  output logic act_pin
);
  logic [4:0] gap_r = 5'h00;
  assign valid_pin = link_up;
  // frames every 40 cycles keep the activity hold retriggered
  always @(posedge pclk) begin
    gap_r <= (gap_r == 5'h13) ? 5'h00 : gap_r + 5'h01;
    if (gap_r == 5'h13) begin
      act_pin <= traffic_en & link_up & ~act_pin;
    end
  end
  initial act_pin = 1'b0;
endmodule
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fai_pkg::*;
  localparam int MS = 2;
  // steady means held past the longest dark gap of any pattern
  localparam int LIM = 1300 * MS;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] sw_hi = 4'h0;
  logic [3:0] sw_lo = 4'h0;
  logic link_up = 1'b0;
  logic traffic_en = 1'b0;
  logic valid_pin;
  logic act_pin;
  logic sync_err = 1'b0;
  logic boot_err = 1'b0;
  logic [7:0] station_alias;
  logic link_led;
  logic state_led;
  logic error_led;
  logic irq;
  int miscompares = 0;
  int n_checks = 0;
  logic [31:0] gc [6];
  fai_pat_e gp [6];

  always #12.5 pclk = ~pclk;

  fai_indicators #(.MS_CYCLES_P(MS)) fai_indicators_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alias_high_digit_switch(sw_hi), .alias_low_digit_switch(sw_lo),
    .link_valid_pin(valid_pin), .link_activity_pin(act_pin), .sync_err_pulse(sync_err),
    .boot_err_pulse(boot_err), .station_alias(station_alias), .link_led(link_led),
    .state_led(state_led), .error_led(error_led), .irq(irq)
  );
  fai_net_model fai_net_model_i (
    .pclk(pclk), .link_up(link_up), .traffic_en(traffic_en), .valid_pin(valid_pin),
    .act_pin(act_pin)
  );

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // the slave has no fixed latency assumed here; only the watchdog ends a hung wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk($sformatf("reg %h", a), e, rd);
    chk($sformatf("pslverr %h", a), {31'h0, ee}, {31'h0, err});
  endtask

  task automatic pulse(input bit boot);
    @(posedge pclk);
    if (boot) boot_err <= 1'b1;
    else sync_err <= 1'b1;
    @(posedge pclk);
    boot_err <= 1'b0;
    sync_err <= 1'b0;
  endtask

  task automatic chk_irq(input logic e);
    @(negedge pclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  function automatic logic ledv(input int w);
    case (w)
      0: return link_led;
      1: return state_led;
      default: return error_led;
    endcase
  endfunction

  task automatic run(input int w, input logic l, output int c);
    c = 0;
    while (ledv(w) === l && c < LIM) begin
      @(negedge pclk);
      c++;
    end
  endtask

  // restart is seen in the lit phase; steady levels held past the longest dark gap
  task automatic check_pat(input int w, input fai_pat_e p);
    int len [4];
    int e [4];
    int n;
    logic lvl;
    case (p)
      PAT_BLINK: e = '{200, 200, 200, 200};
      PAT_SINGLE: e = '{200, 1000, 200, 1000};
      PAT_DOUBLE: e = '{200, 200, 200, 1000};
      default: e = '{50, 50, 50, 50};
    endcase
    lvl = (p != PAT_OFF);
    n = 0;
    while (ledv(w) !== lvl && n < 8) begin
      @(negedge pclk);
      n++;
    end
    chk($sformatf("led %0d start", w), {31'h0, lvl}, {31'h0, ledv(w)});
    if (p == PAT_ON || p == PAT_OFF) begin
      run(w, lvl, n);
      chk($sformatf("led %0d steady", w), LIM, n);
    end else begin
      run(w, 1'b1, n);
      run(w, 1'b0, n);
      for (int k = 0; k < 4; k++) run(w, k % 2 == 0, len[k]);
      if (p == PAT_DOUBLE && len[1] > 300 * MS) e = '{200, 1000, 200, 200};
      for (int k = 0; k < 4; k++) chk($sformatf("led %0d phase", w), e[k] * MS, len[k]);
    end
  endtask

  task automatic test_done(input string nm);
    $display("test %s done", nm);
  endtask

  initial begin
    repeat (80000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end

  initial begin
    gc = '{ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP, ST_BOOT, ST_OP | 32'h20};
    gp = '{PAT_OFF, PAT_BLINK, PAT_SINGLE, PAT_ON, PAT_FLICK, PAT_FLICK};
    repeat (5) @(posedge pclk);
    chk("reset outs", 32'h0, {station_alias, link_led, state_led, error_led, irq});
    presetn <= 1'b1;
    check_pat(1, PAT_FLICK);
    rd_chk(ADDR_CTRL, 32'h11, 1'b0);
    rd_chk(ADDR_STAT, 32'h01, 1'b0);
    wr(ADDR_STAT, 32'hFF);
    rd_chk(ADDR_STAT, 32'h01, 1'b0);
    rd_chk(ADDR_ERR, 32'h0, 1'b0);
    rd_chk(ADDR_IRQ_EN, 32'h0, 1'b0);
    rd_chk(ADDR_IRQ_STAT, 32'h0, 1'b0);
    rd_chk(8'h40, 32'h0, 1'b1);
    test_done("reset");
    wr(ADDR_NVALIAS, 32'h5A);
    sw_hi <= 4'hF;
    sw_lo <= 4'hD;
    repeat (12) @(posedge pclk);
    chk("alias FD", 32'hFD, {24'h0, station_alias});
    sw_hi <= 4'h0;
    sw_lo <= 4'h1;
    repeat (12) @(posedge pclk);
    chk("alias 01", 32'h01, {24'h0, station_alias});
    sw_lo <= 4'h0;
    repeat (12) @(posedge pclk);
    chk("alias store", 32'h5A, {24'h0, station_alias});
    test_done("alias");
    link_up <= 1'b1;
    repeat (12) @(posedge pclk);
    check_pat(0, PAT_ON);
    @(posedge pclk);
    traffic_en <= 1'b1;
    repeat (30) @(posedge pclk);
    check_pat(0, PAT_FLICK);
    @(posedge pclk);
    traffic_en <= 1'b0;
    repeat (400) @(posedge pclk);
    check_pat(0, PAT_ON);
    @(posedge pclk);
    link_up <= 1'b0;
    repeat (12) @(posedge pclk);
    check_pat(0, PAT_OFF);
    test_done("link");
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CTRL, gc[i]);
      check_pat(1, gp[i]);
    end
    test_done("green");
    wr(ADDR_CTRL, 32'(ST_OP));
    wr(ADDR_IRQ_CLR, 32'hF);
    wr(ADDR_IRQ_EN, 32'hF);
    pulse(1'b0);
    rd_chk(ADDR_STAT, 32'h5A14, 1'b0);
    rd_chk(ADDR_IRQ_STAT, 32'h6, 1'b0);
    chk_irq(1'b1);
    check_pat(2, PAT_SINGLE);
    wr(ADDR_IRQ_EN, 32'h0);
    chk_irq(1'b0);
    wr(ADDR_IRQ_EN, 32'hF);
    chk_irq(1'b1);
    wr(ADDR_IRQ_CLR, 32'hF);
    chk_irq(1'b0);
    rd_chk(ADDR_IRQ_STAT, 32'h0, 1'b0);
    rd_chk(ADDR_IRQ_CLR, 32'h0, 1'b0);
    wr(8'h40, 32'hFF);
    rd_chk(ADDR_IRQ_EN, 32'hF, 1'b0);
    test_done("events");
    wr(ADDR_ERR, 32'h1);
    check_pat(2, PAT_BLINK);
    wr(ADDR_ERR, 32'h3);
    check_pat(2, PAT_DOUBLE);
    wr(ADDR_ERR, 32'h7);
    check_pat(2, PAT_ON);
    wr(ADDR_ERR, 32'h3);
    pulse(1'b1);
    rd_chk(ADDR_STAT, 32'h5A31, 1'b0);
    rd_chk(ADDR_IRQ_STAT, 32'hA, 1'b0);
    check_pat(2, PAT_FLICK);
    check_pat(1, PAT_OFF);
    wr(ADDR_ERR, 32'h7);
    check_pat(2, PAT_ON);
    wr(ADDR_ERR, 32'h0);
    wr(ADDR_CTRL, ST_INIT | 32'h40);
    rd_chk(ADDR_STAT, 32'h5A01, 1'b0);
    check_pat(2, PAT_OFF);
    test_done("red");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("mid reset outs", 32'h0, {station_alias, link_led, state_led, error_led, irq});
    presetn <= 1'b1;
    rd_chk(ADDR_NVALIAS, 32'h0, 1'b0);
    rd_chk(ADDR_CTRL, 32'h11, 1'b0);
    check_pat(1, PAT_FLICK);
    test_done("mid reset");
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> verilog/fai_indicators.sv
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R01] alias is high switch digit then low switch digit, giving 1 to 255
// [R02] both digits zero: alias comes from the nonvolatile parameter store; here nv_alias_r, which presetn clears to 0
// [R03] link led steady on valid idle link, flickers on traffic, dark if invalid
// [R04] green state led steadily lit in OPERATIONAL
// [R05] green blinks 200 ms on, 200 ms off in PRE-OPERATIONAL
// [R06] green single flash 200 ms then 1000 ms dark in SAFE-OPERATIONAL
// [R07] green flickers 50/50 ms while booting, in BOOTSTRAP or firmware download
// [R08] green dark in INIT
// [R09] red steadily lit on process data interface watchdog timeout
// [R10] red blinks 200/200 ms on general configuration error
// [R11] boot error: go to INIT, set change flag, red flickers 50/50 ms
// [R12] autonomous state change sets change flag, red single flash
// [R13] sync error drops OPERATIONAL to SAFE-OPERATIONAL as autonomous change
// [R14] application watchdog: red double flash 200/200/200 ms then 1000 ms dark
// [R15] one shared millisecond timebase; patterns restart cleanly on change
// [R16] red shows the most severe error; interface watchdog ranks highest
module fai_indicators #(
  parameter int MS_CYCLES_P = fai_pkg::MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [fai_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] alias_high_digit_switch,
  input wire logic [3:0] alias_low_digit_switch,
  input wire logic link_valid_pin,
  input wire logic link_activity_pin,
  input wire logic sync_err_pulse,
  input wire logic boot_err_pulse,
  output logic [7:0] station_alias,
  output logic link_led,
  output logic state_led,
  output logic error_led,
  output logic irq
);
  import fai_pkg::*;

  localparam int DIV_W = $clog2(MS_CYCLES_P + 1);

  // pins from outside the clock domain
  fai_pins_s pins_raw;
  fai_pins_s pins_s;

  assign pins_raw.hi = alias_high_digit_switch;
  assign pins_raw.lo = alias_low_digit_switch;
  assign pins_raw.valid = link_valid_pin;
  assign pins_raw.act = link_activity_pin;

  fai_sync #(
    .W($bits(fai_pins_s))
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(pins_raw),
    .q(pins_s)
  );

  // millisecond timebase shared by every pattern
  logic [DIV_W-1:0] div_r;
  wire logic ms_tick;

  assign ms_tick = div_r == DIV_W'(MS_CYCLES_P - 1); // [R15]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
    end else begin
      div_r <= ms_tick ? '0 : div_r + DIV_W'(1);
    end
  end

  // apb decode; zero wait states, read data latched in the setup cycle
  wire logic setup_ph;
  wire logic access_ph;
  wire logic hit_ctrl;
  wire logic hit_err;
  wire logic hit_stat;
  wire logic hit_nv;
  wire logic hit_ist;
  wire logic hit_iclr;
  wire logic hit_ien;
  wire logic addr_ok;
  wire logic wr_ctrl;
  wire logic wr_err;
  wire logic wr_nv;
  wire logic wr_iclr;
  wire logic wr_ien;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit_ctrl = paddr == ADDR_CTRL;
  assign hit_err = paddr == ADDR_ERR;
  assign hit_stat = paddr == ADDR_STAT;
  assign hit_nv = paddr == ADDR_NVALIAS;
  assign hit_ist = paddr == ADDR_IRQ_STAT;
  assign hit_iclr = paddr == ADDR_IRQ_CLR;
  assign hit_ien = paddr == ADDR_IRQ_EN;
  assign addr_ok = hit_ctrl | hit_err | hit_stat | hit_nv | hit_ist | hit_iclr | hit_ien;
  assign wr_ctrl = access_ph & pwrite & hit_ctrl;
  assign wr_err = access_ph & pwrite & hit_err;
  assign wr_nv = access_ph & pwrite & hit_nv;
  assign wr_iclr = access_ph & pwrite & hit_iclr;
  assign wr_ien = access_ph & pwrite & hit_ien;
  assign pready = 1'b1;
  assign pslverr = access_ph & ~addr_ok;

  // control and status state
  logic [STATE_W-1:0] state_r;
  logic booting_r;
  logic fwdl_r;
  logic chg_r;
  logic boot_fail_r;
  fai_err_s err_r;
  logic [7:0] nv_alias_r;
  logic [7:0] station_alias_r;
  logic [IRQ_W-1:0] ist_r;
  logic [IRQ_W-1:0] ien_r;
  logic [31:0] prdata_r;
  logic act_q_r;
  logic valid_q_r;
  logic [HOLD_W-1:0] hold_r;

  wire logic sync_hit;
  wire logic ack_chg;
  wire logic [STATE_W-1:0] state_nxt;
  wire logic chg_nxt;
  wire logic boot_fail_nxt;
  wire logic booting_nxt;

  // hardware events win over a software write in the same cycle
  assign sync_hit = sync_err_pulse & (state_r == ST_OP);
  assign ack_chg = wr_ctrl & pwdata[CTRL_ACK_BIT];
  assign state_nxt = boot_err_pulse ? ST_INIT : // [R11]
                     sync_hit ? ST_SAFEOP : // [R13]
                     wr_ctrl ? pwdata[STATE_W-1:0] : state_r;
  assign chg_nxt = boot_err_pulse | sync_hit | (chg_r & ~ack_chg); // [R11] [R12] [R13]
  assign boot_fail_nxt = boot_err_pulse | (boot_fail_r & ~ack_chg); // [R11]
  assign booting_nxt = boot_err_pulse ? 1'b0 : (wr_ctrl ? pwdata[CTRL_BOOT_BIT] : booting_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= STATE_RST;
      booting_r <= BOOTING_RST;
      fwdl_r <= 1'b0;
      chg_r <= 1'b0;
      boot_fail_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      booting_r <= booting_nxt;
      fwdl_r <= wr_ctrl ? pwdata[CTRL_FWDL_BIT] : fwdl_r;
      chg_r <= chg_nxt;
      boot_fail_r <= boot_fail_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= '0;
      nv_alias_r <= NVALIAS_RST;
      ien_r <= '0;
    end else begin
      if (wr_err) begin
        err_r <= pwdata[ERR_W-1:0];
      end
      if (wr_nv) begin
        nv_alias_r <= pwdata[7:0];
      end
      if (wr_ien) begin
        ien_r <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // station alias
  wire logic alias_zero;
  wire logic [7:0] sw_alias;
  wire logic [7:0] alias_nxt;

  assign sw_alias = {pins_s.hi, pins_s.lo}; // [R01]
  assign alias_zero = sw_alias == 8'h00;
  assign alias_nxt = alias_zero ? nv_alias_r : sw_alias; // [R02]
  assign station_alias = station_alias_r;

  // link activity is a short pulse, so it is stretched to keep the flicker visible
  wire logic act_rise;
  wire logic link_chg;

  assign act_rise = pins_s.act & ~act_q_r;
  assign link_chg = pins_s.valid ^ valid_q_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      station_alias_r <= 8'h00;
      act_q_r <= 1'b0;
      valid_q_r <= 1'b0;
      hold_r <= '0;
    end else begin
      station_alias_r <= alias_nxt;
      act_q_r <= pins_s.act;
      valid_q_r <= pins_s.valid;
      if (act_rise) begin
        hold_r <= HOLD_W'(ACT_HOLD_MS);
      end else if (ms_tick && hold_r != '0) begin
        hold_r <= hold_r - HOLD_W'(1);
      end
    end
  end

  // pattern selection
  fai_pat_e link_sel;
  fai_pat_e green_sel;
  fai_pat_e red_sel;
  wire logic green_flick;

  assign link_sel = !pins_s.valid ? PAT_OFF : // [R03]
                    (hold_r != '0) ? PAT_FLICK : PAT_ON;
  assign green_flick = booting_r | fwdl_r | (state_r == ST_BOOT);
  assign green_sel = green_flick ? PAT_FLICK : // [R07]
                     (state_r == ST_OP) ? PAT_ON : // [R04]
                     (state_r == ST_SAFEOP) ? PAT_SINGLE : // [R06]
                     (state_r == ST_PREOP) ? PAT_BLINK : PAT_OFF; // [R05] [R08]
  assign red_sel = err_r.pdi_wdt ? PAT_ON : // [R09] [R16]
                   boot_fail_r ? PAT_FLICK : // [R11]
                   err_r.app_wdt ? PAT_DOUBLE : // [R14]
                   err_r.cfg_err ? PAT_BLINK : // [R10]
                   chg_r ? PAT_SINGLE : PAT_OFF; // [R12]

  fai_led_pattern u_link (
    .clk(pclk),
    .rst_n(presetn),
    .tick(ms_tick),
    .sel(link_sel),
    .led(link_led)
  );

  fai_led_pattern u_green (
    .clk(pclk),
    .rst_n(presetn),
    .tick(ms_tick),
    .sel(green_sel),
    .led(state_led)
  );

  fai_led_pattern u_red (
    .clk(pclk),
    .rst_n(presetn),
    .tick(ms_tick),
    .sel(red_sel),
    .led(error_led)
  );

  // interrupts: sticky status, set wins over a clear in the same cycle
  wire logic [IRQ_W-1:0] irq_ev;
  wire logic [IRQ_W-1:0] irq_clr;

  assign irq_ev[IRQ_LINK] = link_chg;
  assign irq_ev[IRQ_CHG] = boot_err_pulse | sync_hit;
  assign irq_ev[IRQ_SYNC] = sync_hit;
  assign irq_ev[IRQ_BOOT] = boot_err_pulse;
  assign irq_clr = wr_iclr ? pwdata[IRQ_W-1:0] : '0;
  assign irq = |(ist_r & ien_r);

  // read mux
  wire logic [31:0] ctrl_rd;
  wire logic [31:0] stat_rd;
  wire logic [31:0] rd_data;

  assign ctrl_rd = {25'h0, 1'b0, fwdl_r, booting_r, state_r};
  assign stat_rd = {16'h0000, station_alias_r, ~alias_zero, pins_s.valid, boot_fail_r, chg_r,
                    state_r};
  assign rd_data = hit_ctrl ? ctrl_rd :
                   hit_err ? 32'(err_r) :
                   hit_stat ? stat_rd :
                   hit_nv ? 32'(nv_alias_r) :
                   hit_ist ? 32'(ist_r) :
                   hit_ien ? 32'(ien_r) : 32'h00000000;
  assign prdata = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= '0;
      prdata_r <= 32'h00000000;
    end else begin
      ist_r <= irq_ev | (ist_r & ~irq_clr);
      if (setup_ph && !pwrite) begin
        prdata_r <= rd_data;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_alias_sw;
    !alias_zero |=> station_alias == $past(sw_alias);
  endproperty
  a_alias_sw: assert property (p_alias_sw) else $error("switch alias not taken"); // [R01]

  property p_alias_nv;
    alias_zero |=> station_alias == $past(nv_alias_r);
  endproperty
  a_alias_nv: assert property (p_alias_nv) else $error("stored alias not taken"); // [R02]

  property p_link_off;
    !pins_s.valid |=> !link_led;
  endproperty
  a_link_off: assert property (p_link_off) else $error("link led lit on bad link"); // [R03]

  property p_link_on;
    pins_s.valid && hold_r == '0 |=> link_led;
  endproperty
  a_link_on: assert property (p_link_on) else $error("idle link led dark"); // [R03]

  property p_op_on;
    state_r == ST_OP && !green_flick |=> state_led;
  endproperty
  a_op_on: assert property (p_op_on) else $error("state led dark in operational"); // [R04]

  property p_init_off;
    state_r == ST_INIT && !green_flick |=> !state_led;
  endproperty
  a_init_off: assert property (p_init_off) else $error("state led lit in init"); // [R08]

  property p_pdi_on;
    err_r.pdi_wdt |=> error_led;
  endproperty
  a_pdi_on: assert property (p_pdi_on) else $error("red led dark on watchdog"); // [R09] [R16]

  property p_boot;
    boot_err_pulse |=> state_r == ST_INIT && chg_r && (err_r.pdi_wdt || red_sel == PAT_FLICK);
  endproperty
  a_boot: assert property (p_boot) else $error("boot error not handled"); // [R11]

  property p_sync;
    sync_err_pulse && state_r == ST_OP && !boot_err_pulse
      |=> state_r == ST_SAFEOP && chg_r && ist_r[IRQ_SYNC];
  endproperty
  a_sync: assert property (p_sync) else $error("sync error did not drop state"); // [R13]

  property p_chg_single;
    chg_r && !boot_fail_r && err_r == '0 |-> red_sel == PAT_SINGLE;
  endproperty
  a_chg_single: assert property (p_chg_single) else $error("change not single flash"); // [R12]

  c_preop: cover property (state_r == ST_PREOP && !green_flick ##1 state_led);
  c_sync: cover property (sync_hit ##1 chg_r);
  c_alias_nv: cover property (alias_zero && nv_alias_r != 8'h00);
  c_irq: cover property (irq ##1 wr_iclr);
endmodule
`default_nettype wire

// >>> verilog/fai_led_pattern.sv
`timescale 1ns/1ps
`default_nettype none
module fai_led_pattern (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire fai_pkg::fai_pat_e sel,
  output logic led
);
  import fai_pkg::*;

  fai_pat_e sel_q_r;
  logic [CNT_W-1:0] cnt_r;
  logic led_r;
  wire logic restart;
  wire logic wrap;
  wire logic [CNT_W-1:0] cnt_nxt;

  function automatic logic [CNT_W-1:0] period(input fai_pat_e p);
    case (p)
      PAT_BLINK: period = CNT_W'(2 * T_ON_MS);
      PAT_FLICK: period = CNT_W'(2 * T_FLICK_MS);
      PAT_SINGLE: period = CNT_W'(T_ON_MS + T_PAUSE_MS);
      PAT_DOUBLE: period = CNT_W'(3 * T_ON_MS + T_PAUSE_MS);
      default: period = CNT_W'(1);
    endcase
  endfunction

  function automatic logic level(input fai_pat_e p, input logic [CNT_W-1:0] c);
    case (p)
      PAT_ON: level = 1'b1;
      PAT_BLINK: level = c < T_ON_MS;
      PAT_FLICK: level = c < T_FLICK_MS;
      PAT_SINGLE: level = c < T_ON_MS;
      PAT_DOUBLE: level = (c < T_ON_MS) || (c >= 2 * T_ON_MS && c < 3 * T_ON_MS);
      default: level = 1'b0;
    endcase
  endfunction

  // a new pattern always starts at the head of its lit phase
  assign restart = sel != sel_q_r; // [R15]
  assign wrap = cnt_r >= period(sel) - CNT_W'(1);
  assign cnt_nxt = restart ? '0 : (tick ? (wrap ? '0 : cnt_r + CNT_W'(1)) : cnt_r);
  assign led = led_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q_r <= PAT_OFF;
      cnt_r <= '0;
      led_r <= 1'b0;
    end else begin
      sel_q_r <= sel;
      cnt_r <= cnt_nxt;
      led_r <= level(sel, restart ? '0 : cnt_r);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_restart;
    sel != sel_q_r |=> cnt_r == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("pattern did not restart"); // [R15]

  property p_blink;
    sel == PAT_BLINK && !restart |=> led == ($past(cnt_r) < T_ON_MS);
  endproperty
  a_blink: assert property (p_blink) else $error("blink phase wrong"); // [R05] [R10]

  property p_flick;
    sel == PAT_FLICK && !restart |=> led == ($past(cnt_r) < T_FLICK_MS);
  endproperty
  a_flick: assert property (p_flick) else $error("flicker phase wrong"); // [R07] [R11]

  property p_single;
    sel == PAT_SINGLE && !restart && cnt_r >= T_ON_MS |=> !led;
  endproperty
  a_single: assert property (p_single) else $error("single flash lit too long"); // [R06] [R12]

  property p_double;
    sel == PAT_DOUBLE && !restart && cnt_r >= 2 * T_ON_MS && cnt_r < 3 * T_ON_MS |=> led;
  endproperty
  a_double: assert property (p_double) else $error("second flash missing"); // [R14]

  property p_wrap;
    !restart && tick && cnt_r == period(sel) - CNT_W'(1) |=> cnt_r == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pattern period wrong"); // [R15]
endmodule
`default_nettype wire

// >>> verilog/fai_pkg.sv
`default_nettype none
package fai_pkg;
  // clock and timebase
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // indicator phases, in milliseconds
  localparam int T_ON_MS = 200;
  localparam int T_FLICK_MS = 50;
  localparam int T_PAUSE_MS = 1000;
  localparam int ACT_HOLD_MS = 100;
  localparam int CNT_W = 11;
  localparam int HOLD_W = 7;
  // apb map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ERR = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_NVALIAS = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 8'h18;
  // ctrl fields
  localparam int STATE_W = 4;
  localparam int CTRL_BOOT_BIT = 4;
  localparam int CTRL_FWDL_BIT = 5;
  localparam int CTRL_ACK_BIT = 6;
  // network state codes
  localparam logic [STATE_W-1:0] ST_INIT = 4'h1;
  localparam logic [STATE_W-1:0] ST_PREOP = 4'h2;
  localparam logic [STATE_W-1:0] ST_BOOT = 4'h3;
  localparam logic [STATE_W-1:0] ST_SAFEOP = 4'h4;
  localparam logic [STATE_W-1:0] ST_OP = 4'h8;
  // reset values
  localparam logic [STATE_W-1:0] STATE_RST = ST_INIT;
  localparam logic BOOTING_RST = 1'b1;
  localparam logic [7:0] NVALIAS_RST = 8'h00;
  // interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_LINK = 0;
  localparam int IRQ_CHG = 1;
  localparam int IRQ_SYNC = 2;
  localparam int IRQ_BOOT = 3;

  typedef enum logic [2:0] {
    PAT_OFF, PAT_ON, PAT_BLINK, PAT_SINGLE, PAT_DOUBLE, PAT_FLICK
  } fai_pat_e;

  typedef struct packed {
    logic pdi_wdt;
    logic app_wdt;
    logic cfg_err;
  } fai_err_s;
  localparam int ERR_W = $bits(fai_err_s);

  typedef struct packed {
    logic [3:0] hi;
    logic [3:0] lo;
    logic valid;
    logic act;
  } fai_pins_s;
endpackage
`default_nettype wire

// >>> verilog/fai_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fai_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  wire logic [W-1:0] agree;
  wire logic [W-1:0] q_nxt;

  // a bit moves only once the last two stages agree
  assign agree = ~(s2_r ^ s3_r);
  assign q_nxt = (agree & s3_r) | (~agree & q_r);
  assign q = q_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end
endmodule
`default_nettype wire
